// file: logic/flcsr_cfg.svh
`ifndef FLCSR_CFG_SVH
`define FLCSR_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FLCSR_RX_INFO_OFS    8'h7c
`define FLCSR_TX_INFO_OFS    8'h80
`define FLCSR_PWR_CTRL_OFS   8'h84
`define FLCSR_BYTE_TEST_OFS  8'h70

// ----------------------------------------
// field positions
// ----------------------------------------
`define FLCSR_USED_HI        23
`define FLCSR_USED_LO        16
`define FLCSR_BYTES_HI       15
`define FLCSR_BYTES_LO       0
`define FLCSR_PS_HI          13
`define FLCSR_PS_LO          12
`define FLCSR_PHY_SOFT_RESET_BIT    10
`define FLCSR_WAKE_LAN_ENABLE_BIT     9
`define FLCSR_ENERGY_DETECT_ENABLE_BIT      8
`define FLCSR_BUF_TYPE_BIT   6
`define FLCSR_PULSE_SEL_BIT  3
`define FLCSR_POLARITY_BIT   2
`define FLCSR_OUT_EN_BIT     1
`define FLCSR_READY_BIT      0

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define FLCSR_PS_D0          2'h0
`define FLCSR_PS_D1          2'h1
`define FLCSR_PS_D2          2'h2
`define FLCSR_TX_FREE_RST    16'h1200
`define FLCSR_ZERO16         16'h0000
`define FLCSR_DWORD_BYTES    16'h0004

// ----------------------------------------
// timing
// ----------------------------------------
`define FLCSR_CLK_MHZ        100
`define FLCSR_PHY_SOFT_RESET_US     100
`define FLCSR_PHY_SOFT_RESET_CYC    (`FLCSR_PHY_SOFT_RESET_US * `FLCSR_CLK_MHZ)
`define FLCSR_PULSE_MS       50
`define FLCSR_PULSE_CYC      (`FLCSR_PULSE_MS * 1000 * `FLCSR_CLK_MHZ)
`define FLCSR_PULSE_W        23
`define FLCSR_SETTLE_CYC     16

`endif

// file: logic/flcsr_pkg.sv
`default_nettype none

package flcsr_pkg;

	// power sequencing of the host-facing side
	typedef enum logic [1:0]
	{
		PWR_SETTLE,
		PWR_READY,
		PWR_LOW
	} flcsr_pwr_t;

	typedef logic [1:0]  flcsr_ps_t;
	typedef logic [15:0] flcsr_cnt_t;

endpackage

`default_nettype wire

// file: logic/flcsr_pme_if.sv
`timescale 1ns/100ps
`default_nettype none

interface flcsr_pme_if;
	logic wake_lan_enable;
	logic energy_detect_enable;
	logic out_en;
	logic pulse_sel;
	logic polarity;
	logic push_pull;
	logic wol_hit;
	logic ed_hit;
	logic irq;

	modport ctrl
	(
		output wake_lan_enable, energy_detect_enable, out_en, pulse_sel, polarity, push_pull, wol_hit, ed_hit,
		input  irq
	);

	modport pme
	(
		input  wake_lan_enable, energy_detect_enable, out_en, pulse_sel, polarity, push_pull, wol_hit, ed_hit,
		output irq
	);
endinterface // flcsr_pme_if

`default_nettype wire

// file: logic/flcsr_pme_out.sv
`timescale 1ns/100ps
`default_nettype none
`include "flcsr_cfg.svh"

module flcsr_pme_out
	import flcsr_pkg::*;
#(
	parameter int PULSE_CYCLES = `FLCSR_PULSE_CYC
)
(
	input  wire logic   clk,
	input  wire logic   rst_b,
	flcsr_pme_if.pme    pme,
	output logic        pin_out,
	output logic        pin_oe_b
);

	// ----------------------------------------
	// event capture
	// ----------------------------------------
	logic                      seen_wol;
	logic                      seen_ed;
	logic [`FLCSR_PULSE_W-1:0] pulse_cnt;

	wire wol_take = pme.wol_hit & pme.wake_lan_enable;
	wire ed_take  = pme.ed_hit & pme.energy_detect_enable;
	wire trigger  = wol_take | ed_take;
	wire active   = seen_wol | seen_ed;
	wire pulse_on = pulse_cnt != '0;
	wire drive    = pme.out_en & (pme.pulse_sel ? pulse_on : active);
	wire next_out = pme.push_pull & (pme.polarity ? drive : ~drive);
	wire next_oe_b = pme.push_pull ? 1'b0 : ~drive;

	// sticky until its enable drops; a hit is not taken while its enable is low, so the clear wins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seen_wol <= 1'b0;
			seen_ed  <= 1'b0;
		end
		else
		begin
			seen_wol <= wol_take | (seen_wol & pme.wake_lan_enable);
			seen_ed  <= ed_take | (seen_ed & pme.energy_detect_enable);
		end
	end

	// interrupt ignores the pin enable
	assign pme.irq = active;

	// ----------------------------------------
	// pulse timer and pin driver
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pulse_cnt <= '0;
		else if (trigger)
			pulse_cnt <= `FLCSR_PULSE_W'(PULSE_CYCLES);
		else if (pulse_on)
			pulse_cnt <= pulse_cnt - `FLCSR_PULSE_W'(1);
	end

	// open drain pulls low only and disregards polarity
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_out  <= 1'b0;
			pin_oe_b <= 1'b1;
		end
		else
		begin
			pin_out  <= next_out;
			pin_oe_b <= next_oe_b;
		end
	end

endmodule // flcsr_pme_out

`default_nettype wire

// file: logic/flcsr_top.sv
// Functional notes
// - rx status used dwords at bits 23-16
// - rx data used bytes, frames rounded up
// - tx status used dwords, reset zero
// - tx data free bytes, reset 1200h
// - writes ignored until first read after wake
// - power state field selects D0, D1, D2
// - power state self-clears, resets to D0
// - byte test write wakes from low power
// - phy reset held 100us, then self-clears
// - phy reset writes ignored while high
// - wake-lan event drives pin and interrupt
// - energy-detect event drives pin and interrupt
// - buffer type: open drain or push-pull
// - open drain always active low
// - pin enable gates pin, not interrupt
// - pulse style gives 50ms active pulse
// - ready flag readable in every state
`timescale 1ns/100ps
`default_nettype none
`include "flcsr_cfg.svh"

module flcsr_top
	import flcsr_pkg::*;
#(
	parameter int PHY_RESET_CYCLES = `FLCSR_PHY_SOFT_RESET_CYC,
	parameter int PULSE_CYCLES     = `FLCSR_PULSE_CYC
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// fifo datapath events
	input  wire logic        rx_frame_done,
	input  wire logic [15:0] rx_frame_bytes,
	input  wire logic        rx_data_pop,
	input  wire logic        rx_status_pop,
	input  wire logic        tx_data_push,
	input  wire logic        tx_data_pull,
	input  wire logic        tx_status_push,
	input  wire logic        tx_status_pop,
	// wake sources
	input  wire logic        wake_lan_event,
	input  wire logic        energy_detect_event,
	// power control
	output logic      [1:0]  power_state_select,
	output logic             device_ready,
	output logic             phy_soft_reset,
	output logic             power_event_interrupt,
	input  wire logic        power_event_in,
	output logic             power_event_output,
	output logic             power_event_oe_b
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = addr[7:2] == ofs[7:2];
	endfunction

	function automatic flcsr_cnt_t step(input flcsr_cnt_t cur, input flcsr_cnt_t inc, input flcsr_cnt_t dec);
		step = cur + inc - dec;
	endfunction

	function automatic flcsr_cnt_t round_dword(input flcsr_cnt_t len);
		logic [16:0] sum;
		sum = {1'b0, len} + 17'h0_0003;
		round_dword = {sum[15:2], 2'b00};
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	flcsr_pwr_t  pwr_state;
	flcsr_pwr_t  next_pwr_state;
	flcsr_ps_t   ps;
	logic [4:0]  settle_cnt;
	logic [15:0] phy_cnt;
	logic        ack;
	logic        armed;
	logic        wake_lan_enable;
	logic        energy_detect_enable;
	logic        buf_type;
	logic        pulse_sel;
	logic        polarity;
	logic        out_en;
	logic [7:0]  rx_status_used_dwords;
	flcsr_cnt_t  rx_data_used_bytes;
	logic [7:0]  tx_status_used_dwords;
	flcsr_cnt_t  tx_data_free_bytes;
	logic [31:0] pwr_word;
	logic [31:0] rd_mux;

	flcsr_pme_if pme_bus ();

	// ----------------------------------------
	// bus handshake: one wait state per access
	// ----------------------------------------
	wire req     = avs_read | avs_write;
	wire done_rd = avs_read & ack;
	wire done_wr = avs_write & ack;

	assign avs_waitrequest = req & ~ack;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ack <= 1'b0;
		else
			ack <= req & ~ack;
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire sel_rx  = hit(avs_address, `FLCSR_RX_INFO_OFS);
	wire sel_tx  = hit(avs_address, `FLCSR_TX_INFO_OFS);
	wire sel_pwr = hit(avs_address, `FLCSR_PWR_CTRL_OFS);
	wire sel_bt  = hit(avs_address, `FLCSR_BYTE_TEST_OFS);
	wire ready   = pwr_state == PWR_READY;
	wire be_lo   = avs_byteenable[0];
	wire be_hi   = avs_byteenable[1];

	// only byte test acts while unready, no other write before the first read
	wire wr_ok   = done_wr & armed & ready;
	wire wr_lo   = wr_ok & sel_pwr & be_lo;
	wire wr_hi   = wr_ok & sel_pwr & be_hi;

	wire [1:0] ps_wdata = avs_writedata[`FLCSR_PS_HI:`FLCSR_PS_LO];
	wire enter_low = wr_hi & ((ps_wdata == `FLCSR_PS_D1) | (ps_wdata == `FLCSR_PS_D2));
	wire wake_wr   = done_wr & sel_bt & (pwr_state == PWR_LOW);
	wire phy_start = wr_hi & avs_writedata[`FLCSR_PHY_SOFT_RESET_BIT] & ~phy_soft_reset;
	wire phy_done  = phy_soft_reset & (phy_cnt == 16'(PHY_RESET_CYCLES - 1));
	wire settle_done = settle_cnt == 5'(`FLCSR_SETTLE_CYC - 1);

	// ----------------------------------------
	// power sequencing
	// ----------------------------------------
	always_comb
	begin
		case (pwr_state)
			PWR_SETTLE: next_pwr_state = settle_done ? PWR_READY : PWR_SETTLE;
			PWR_READY:  next_pwr_state = enter_low ? PWR_LOW : PWR_READY;
			PWR_LOW:    next_pwr_state = wake_wr ? PWR_SETTLE : PWR_LOW;
			default:    next_pwr_state = PWR_SETTLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pwr_state <= PWR_SETTLE;
		else
			pwr_state <= next_pwr_state;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			settle_cnt <= '0;
		else if (pwr_state == PWR_SETTLE)
			settle_cnt <= settle_cnt + 5'd1;
		else
			settle_cnt <= '0;
	end

	// mode field; 11b is dropped, wake clears it back to D0
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ps <= `FLCSR_PS_D0;
		else if (wake_wr)
			ps <= `FLCSR_PS_D0;
		else if (enter_low)
			ps <= ps_wdata;
	end

	// a read arms writes; entering or leaving low power disarms
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			armed <= 1'b0;
		else if (enter_low | wake_wr)
			armed <= 1'b0;
		else if (done_rd)
			armed <= 1'b1;
	end

	// ----------------------------------------
	// phy reset timer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phy_soft_reset <= 1'b0;
			phy_cnt        <= '0;
		end
		else if (phy_start)
		begin
			phy_soft_reset <= 1'b1;
			phy_cnt        <= '0;
		end
		else if (phy_done)
			phy_soft_reset <= 1'b0;
		else if (phy_soft_reset)
			phy_cnt <= phy_cnt + 16'd1;
	end

	// ----------------------------------------
	// wake event configuration
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wake_lan_enable <= 1'b0;
			energy_detect_enable  <= 1'b0;
		end
		else if (wr_hi)
		begin
			wake_lan_enable <= avs_writedata[`FLCSR_WAKE_LAN_ENABLE_BIT];
			energy_detect_enable  <= avs_writedata[`FLCSR_ENERGY_DETECT_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			buf_type  <= 1'b0;
			pulse_sel <= 1'b0;
			polarity  <= 1'b0;
			out_en    <= 1'b0;
		end
		else if (wr_lo)
		begin
			buf_type  <= avs_writedata[`FLCSR_BUF_TYPE_BIT];
			pulse_sel <= avs_writedata[`FLCSR_PULSE_SEL_BIT];
			polarity  <= avs_writedata[`FLCSR_POLARITY_BIT];
			out_en    <= avs_writedata[`FLCSR_OUT_EN_BIT];
		end
	end

	// ----------------------------------------
	// fifo level tracking
	// ----------------------------------------
	wire flcsr_cnt_t rx_add = rx_frame_done ? round_dword(rx_frame_bytes) : `FLCSR_ZERO16;
	wire flcsr_cnt_t rx_sub = rx_data_pop ? `FLCSR_DWORD_BYTES : `FLCSR_ZERO16;
	wire flcsr_cnt_t tx_add = tx_data_pull ? `FLCSR_DWORD_BYTES : `FLCSR_ZERO16;
	wire flcsr_cnt_t tx_sub = tx_data_push ? `FLCSR_DWORD_BYTES : `FLCSR_ZERO16;
	wire flcsr_cnt_t rxs_next = step({8'h00, rx_status_used_dwords}, 16'(rx_frame_done), 16'(rx_status_pop));
	wire flcsr_cnt_t txs_next = step({8'h00, tx_status_used_dwords}, 16'(tx_status_push), 16'(tx_status_pop));

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_status_used_dwords <= 8'h00;
			rx_data_used_bytes    <= `FLCSR_ZERO16;
			tx_status_used_dwords <= 8'h00;
			tx_data_free_bytes    <= `FLCSR_TX_FREE_RST;
		end
		else
		begin
			rx_status_used_dwords <= rxs_next[7:0];
			rx_data_used_bytes    <= step(rx_data_used_bytes, rx_add, rx_sub);
			tx_status_used_dwords <= txs_next[7:0];
			tx_data_free_bytes    <= step(tx_data_free_bytes, tx_add, tx_sub);
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	assign pwr_word = {18'h0_0000, ps, 1'h0, phy_soft_reset, wake_lan_enable, energy_detect_enable, 1'h0, buf_type, 2'h0,
	                   pulse_sel, polarity, out_en, ready};

	// fifo levels read as zero while unready; power control always readable
	wire [31:0] rx_word = {8'h00, rx_status_used_dwords, rx_data_used_bytes};
	wire [31:0] tx_word = {8'h00, tx_status_used_dwords, tx_data_free_bytes};

	assign rd_mux = sel_pwr           ? pwr_word :
	                (sel_rx & ready)  ? rx_word  :
	                (sel_tx & ready)  ? tx_word  :
	                32'h0000_0000;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~ack)
			avs_readdata <= rd_mux;
	end

	// ----------------------------------------
	// power event output
	// ----------------------------------------
	assign pme_bus.wake_lan_enable    = wake_lan_enable;
	assign pme_bus.energy_detect_enable     = energy_detect_enable;
	assign pme_bus.out_en    = out_en;
	assign pme_bus.pulse_sel = pulse_sel;
	assign pme_bus.polarity  = polarity;
	assign pme_bus.push_pull = buf_type;
	assign pme_bus.wol_hit   = wake_lan_event;
	assign pme_bus.ed_hit    = energy_detect_event;

	flcsr_pme_out
	#(
		.PULSE_CYCLES (PULSE_CYCLES)
	)
	u_pme
	(
		.clk      (clk),
		.rst_b    (rst_b),
		.pme      (pme_bus.pme),
		.pin_out  (power_event_output),
		.pin_oe_b (power_event_oe_b)
	);

	assign power_event_interrupt = pme_bus.irq;
	assign power_state_select    = ps;
	assign device_ready          = ready;

endmodule // flcsr_top

`default_nettype wire

// file: bench/flcsr_properties.sv
`timescale 1ns/100ps
`default_nettype none

module flcsr_props
#(
	parameter int PHY_RESET_CYCLES = 20,
	parameter int PULSE_CYCLES     = 30
)
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        wake_lan_event,
	input wire logic        energy_detect_event,
	input wire logic [1:0]  power_state_select,
	input wire logic        device_ready,
	input wire logic        phy_soft_reset,
	input wire logic        power_event_interrupt,
	input wire logic        power_event_output,
	input wire logic        power_event_oe_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic [15:0] phy_cnt;
	wire         rd_c0   = avs_read && avs_waitrequest;
	wire         wr_done = avs_write && !avs_waitrequest;

	// cycles the phy reset has been high so far
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			phy_cnt <= 16'h0000;
		else
			phy_cnt <= phy_soft_reset ? phy_cnt + 16'h0001 : 16'h0000;

	sequence s_settle;
		(power_state_select == 2'h0 && !device_ready) ##[8:24] device_ready;
	endsequence

	property p_mode_legal; power_state_select != 2'h3; endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("mode field reserved value");
	property p_low_unready; power_state_select != 2'h0 |-> !device_ready; endproperty
	a_low_unready: assert property (p_low_unready) else $error("ready while in low power");
	property p_phy_hold; $fell(phy_soft_reset) |-> phy_cnt == PHY_RESET_CYCLES; endproperty
	a_phy_hold: assert property (p_phy_hold) else $error("phy reset length wrong");
	property p_wake;
		wr_done && avs_address[7:2] == 6'h1c && power_state_select != 2'h0 |=> s_settle;
	endproperty
	a_wake: assert property (p_wake) else $error("byte test write did not wake");
	property p_irq_cause;
		$rose(power_event_interrupt) |-> $past(wake_lan_event) || $past(energy_detect_event);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
	property p_od_low; power_event_oe_b |-> !power_event_output; endproperty
	a_od_low: assert property (p_od_low) else $error("open drain drives high");
	property p_info_rsvd;
		rd_c0 && (avs_address[7:2] == 6'h1f || avs_address[7:2] == 6'h20) |=> avs_readdata[31:24] == 8'h00;
	endproperty
	a_info_rsvd: assert property (p_info_rsvd) else $error("info reserved bits set");
	property p_pmc_read;
		rd_c0 && avs_address[7:2] == 6'h21 |=> avs_readdata[13:12] == $past(power_state_select)
			&& avs_readdata[10] == $past(phy_soft_reset) && avs_readdata[0] == $past(device_ready)
			&& avs_readdata[31:14] == '0 && avs_readdata[11] == 1'b0 && avs_readdata[7] == 1'b0;
	endproperty
	a_pmc_read: assert property (p_pmc_read) else $error("power control readback wrong");
endmodule // flcsr_props

`default_nettype wire

// file: bench/flcsr_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module flcsr_host_model
(
	input  wire logic        clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable
);
	initial
	begin
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hf;
	end

	// request held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_writedata <= ~d;
	endtask
endmodule // flcsr_host_model

`default_nettype wire

// file: bench/fifo_level_and_power_csrs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "flcsr_cfg.svh"

module fifo_level_and_power_csrs_tb_top;
	localparam int PHY_CYC   = 20;
	localparam int PULSE_CYC = 30;
	logic        clk, rst_b, wake_lan_event, energy_detect_event, avs_read, avs_write, avs_waitrequest;
	logic        device_ready, phy_soft_reset, power_event_interrupt, power_event_output, power_event_oe_b;
	logic [7:0]  avs_address, rx_stat, tx_stat;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	logic [15:0] rx_frame_bytes, rx_bytes, tx_free, n;
	logic [1:0]  power_state_select;
	logic [6:0]  strobes;
	logic        ok;
	wire         rx_frame_done, rx_data_pop, rx_status_pop, tx_data_push, tx_data_pull, tx_status_push, tx_status_pop;
	wire         pin_level = power_event_oe_b ? 1'b1 : power_event_output;
	int          mismatches, total_checks, cyc, phy_hi, op, lows;

	assign {tx_status_pop, tx_status_push, tx_data_pull, tx_data_push, rx_status_pop, rx_data_pop, rx_frame_done} = strobes;

	flcsr_top #(.PHY_RESET_CYCLES(PHY_CYC), .PULSE_CYCLES(PULSE_CYC)) i_dut (.clk(clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_frame_done(rx_frame_done), .rx_frame_bytes(rx_frame_bytes), .rx_data_pop(rx_data_pop),
		.rx_status_pop(rx_status_pop), .tx_data_push(tx_data_push), .tx_data_pull(tx_data_pull),
		.tx_status_push(tx_status_push), .tx_status_pop(tx_status_pop), .wake_lan_event(wake_lan_event),
		.energy_detect_event(energy_detect_event), .power_state_select(power_state_select),
		.device_ready(device_ready), .phy_soft_reset(phy_soft_reset), .power_event_interrupt(power_event_interrupt),
		.power_event_in(pin_level), .power_event_output(power_event_output), .power_event_oe_b(power_event_oe_b));

	flcsr_host_model i_host (.clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (phy_soft_reset === 1'b1)
			phy_hi++;
		if (cyc == 5000)
		begin
			mismatches++;
			close_out();
		end
	end

	function automatic logic [15:0] rnd_dword(input logic [15:0] len);
		return (len + 16'h0003) & 16'hfffc;
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task rd(input logic [7:0] a);
		i_host.xfer(1'b0, a, 32'h0000_0000, q);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q);
	endtask

	task wait_ready;
		for (int i = 0; i < 100 && device_ready !== 1'b1; i++)
			@(posedge clk);
	endtask

	task check_info;
		@(posedge clk);
		strobes <= 7'h00;
		rd(`FLCSR_RX_INFO_OFS);
		chk("rx_info", {8'h00, rx_stat, rx_bytes}, q);
		rd(`FLCSR_TX_INFO_OFS);
		chk("tx_info", {8'h00, tx_stat, tx_free}, q);
	endtask

	task automatic fire(input logic wl);
		@(posedge clk);
		{wake_lan_event, energy_detect_event} <= {wl, !wl};
		@(posedge clk);
		{wake_lan_event, energy_detect_event} <= 2'b00;
		lows = 0;
		repeat (60) @(negedge clk) if (power_event_oe_b === 1'b0 && power_event_output === 1'b0) lows++;
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{rst_b, wake_lan_event, energy_detect_event, strobes, rx_frame_bytes} = '0;
		{rx_bytes, rx_stat, tx_stat, tx_free} = {16'h0000, 8'h00, 8'h00, 16'h1200};
		void'($urandom(6089));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		wait_ready();
		wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_0200);
		rd(`FLCSR_PWR_CTRL_OFS);
		chk("pmc_unarmed", 32'h0000_0001, q);
		wr(`FLCSR_PWR_CTRL_OFS, 32'hffff_ffff);
		rd(`FLCSR_PWR_CTRL_OFS);
		chk("pmc_all", 32'h0000_074f, q);
		wr(`FLCSR_PWR_CTRL_OFS, 32'hffff_ffff);
		repeat (30) @(posedge clk);
		chk("phy_len", PHY_CYC, phy_hi);
		rd(`FLCSR_PWR_CTRL_OFS);
		chk("pmc_phy_done", 32'h0000_034f, q);
		rd(8'h40);
		chk("unmapped", 32'h0000_0000, q);
		wr(`FLCSR_RX_INFO_OFS, 32'hffff_ffff);
		check_info();
		for (int i = 0; i < 200; i++)
		begin
			op = $urandom_range(0, 6);
			n = 16'($urandom_range(1, 1518));
			ok = op == 1 ? rx_bytes >= 16'h0004 : op == 2 ? rx_stat != 8'h00 : op == 3 ? tx_free >= 16'h0004 :
				op == 4 ? tx_free <= 16'h11fc : op == 6 ? tx_stat != 8'h00 : 1'b1;
			@(posedge clk);
			rx_frame_bytes <= n;
			strobes <= ok ? 7'h01 << op : 7'h00;
			if (ok)
			begin
				rx_bytes += op == 0 ? rnd_dword(n) : op == 1 ? 16'hfffc : 16'h0000;
				rx_stat  += op == 0 ? 8'h01 : op == 2 ? 8'hff : 8'h00;
				tx_free  += op == 3 ? 16'hfffc : op == 4 ? 16'h0004 : 16'h0000;
				tx_stat  += op == 5 ? 8'h01 : op == 6 ? 8'hff : 8'h00;
			end
			if (i % 40 == 39)
				check_info();
		end
		wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_000a);
		fire(1'b0);
		chk("ed_masked", 32'h0000_0000, {power_event_interrupt, 31'(lows)});
		wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_010e);
		fire(1'b0);
		chk("ed_irq", 32'h0000_0001, {31'h0, power_event_interrupt});
		chk("pulse_len", PULSE_CYC, lows);
		wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_0244);
		fire(1'b1);
		chk("wol_irq", 32'h0000_0001, {31'h0, power_event_interrupt});
		chk("pp_drive", 60, lows);
		chk("pin_gated", 32'h0000_0000, {31'h0, power_event_output});
		wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_0246);
		repeat (3) @(negedge clk);
		chk("pin_level_hi", 32'h0000_0001, {31'h0, power_event_output});
		wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_0242);
		repeat (3) @(negedge clk);
		chk("pin_level_lo", 32'h0000_0000, {31'h0, power_event_output});
		for (int m = 1; m < 3; m++)
		begin
			wr(`FLCSR_PWR_CTRL_OFS, 32'(m) << 12);
			@(negedge clk);
			chk("low_mode", 32'(m), {30'h0, power_state_select});
			rd(`FLCSR_PWR_CTRL_OFS);
			chk("low_read", 32'(m) << 12, q);
			wr(`FLCSR_BYTE_TEST_OFS, $urandom());
			wait_ready();
			@(negedge clk);
			chk("woke", 32'h0000_0001, {29'h0, power_state_select, device_ready});
			wr(`FLCSR_PWR_CTRL_OFS, 32'h0000_0002);
			rd(`FLCSR_PWR_CTRL_OFS);
			chk("wake_unarmed", 32'h0000_0001, q);
		end
		close_out();
	end
endmodule // fifo_level_and_power_csrs_tb_top

bind flcsr_top flcsr_props #(.PHY_RESET_CYCLES(PHY_RESET_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) i_props (
	.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wake_lan_event(wake_lan_event),
	.energy_detect_event(energy_detect_event), .power_state_select(power_state_select),
	.device_ready(device_ready), .phy_soft_reset(phy_soft_reset), .power_event_interrupt(power_event_interrupt),
	.power_event_output(power_event_output), .power_event_oe_b(power_event_oe_b));

`default_nettype wire
